// >>> pin_mux_pkg.sv
// Constants, register map and helpers shared by the pin function selector.
// Assumes a single 200 MHz core clock and an Avalon-MM register master.
// Notes on behaviour
// - Reset returns every pad to its primary function.
// - Each pad direction is set on its own.
// - Asserted fault input disables the selected PWM outputs.
// - Test data and mode sampled on test-clock rise.
// - Test data out driven only while shifting, falls.
// - Low reset pad initialises and holds the device.
// - Reset release is synchronous, fixed cycles after pad.
// - Reset pad as I/O ignores pad reset.
// - In reset, pads are pulled-up inputs; data-out stays output.
// - Converter control picks converter or comparator routing.
package pin_mux_pkg;
  localparam int NPADS = 8;
  localparam int NFUNC = 4;
  localparam int SELW = 2;
  localparam int RST_CNT_W = 6;
  localparam logic [RST_CNT_W-1:0] RST_RELEASE_CYCLES = 6'h20;

  localparam logic [7:0] OFS_PER = 8'h00;
  localparam logic [7:0] OFS_SEL = 8'h04;
  localparam logic [7:0] OFS_DIR = 8'h08;
  localparam logic [7:0] OFS_DOUT = 8'h0c;
  localparam logic [7:0] OFS_DIN = 8'h10;
  localparam logic [7:0] OFS_PULL = 8'h14;
  localparam logic [7:0] OFS_CTL = 8'h18;
  localparam logic [7:0] OFS_FMASK = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;

  localparam logic [NPADS-1:0] PER_RST = 8'h00;
  localparam logic [NPADS*SELW-1:0] SEL_RST = 16'h0000;
  localparam logic [NPADS-1:0] DIR_RST = 8'h00;
  localparam logic [NPADS-1:0] DOUT_RST = 8'h00;
  localparam logic [NPADS-1:0] PULL_RST = 8'hff;
  localparam logic [4:0] CTL_RST = 5'h04;
  localparam logic [NPADS-1:0] FMASK_RST = 8'h00;

  localparam int CTL_RSTIO = 0;
  localparam int CTL_SWRST = 1;
  localparam int CTL_FPOL = 2;
  localparam int CTL_CMPSEL = 3;
  localparam int CTL_RSTDRV = 4;

  localparam int STAT_FAULT = 0;
  localparam int STAT_SHIFT = 1;
  localparam int STAT_RSTPAD = 2;
  localparam int STAT_CMPSEL = 3;

  localparam int FAULT_PAD = 6;
  localparam logic [SELW-1:0] FAULT_SEL = 2'h2;
  localparam int ANALOG_PAD = 1;
  localparam logic [SELW-1:0] ANALOG_SEL = 2'h0;

  typedef enum logic [0:0] {bus_idle, bus_ack} bus_state_type;

  function automatic logic [SELW-1:0] pad_sel(input logic [NPADS*SELW-1:0] s, input int i);
    pad_sel = s[i*SELW +: SELW];
  endfunction
endpackage

// >>> pad_route.sv
// Combinational routing of one pad between general I/O and its alternates.
// Assumes the caller registers the pad-side outputs.
`timescale 1ns/1ps
module pad_route
  import pin_mux_pkg::*;
(
  input wire logic per_en_i,
  input wire logic [SELW-1:0] sel_i,
  input wire logic gpio_dir_i,
  input wire logic gpio_out_i,
  input wire logic [NFUNC-1:0] alt_out_i,
  input wire logic [NFUNC-1:0] alt_oe_i,
  input wire logic pad_in_i,
  output logic pad_out_o,
  output logic pad_oe_o,
  output logic [NFUNC-1:0] alt_in_o
);
  always_comb begin
    alt_in_o = '0;
    if (per_en_i) begin
      pad_out_o = alt_out_i[sel_i];
      pad_oe_o = alt_oe_i[sel_i];
      alt_in_o[sel_i] = pad_in_i;
    end else begin
      // Unselected peripherals see zero so none can sample a GPIO pad.
      pad_out_o = gpio_out_i;
      pad_oe_o = gpio_dir_i;
    end
  end
endmodule

// >>> reset_release.sv
// Internal reset generator: holds reset while requested, releases after a count.
// Assumes the request is synchronous to the core clock.
`timescale 1ns/1ps
module reset_release
  import pin_mux_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  output logic sys_rst_n_o
);
  logic [RST_CNT_W-1:0] cnt_q;
  logic rst_n_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      rst_n_q <= 1'b0;
    end else if (req_i) begin
      cnt_q <= '0;
      rst_n_q <= 1'b0;
    end else if (cnt_q != RST_RELEASE_CYCLES) begin
      cnt_q <= cnt_q + 1'b1;
    end else begin
      rst_n_q <= 1'b1;
    end
  end

  assign sys_rst_n_o = rst_n_q;
endmodule

// >>> pin_function_selector.sv
// Pin function selector: pad multiplexing, reset pad, test pads and fault gating.
// Assumes an Avalon-MM master on the core clock and synchronous pad inputs.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module pin_function_selector
  import pin_mux_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [NPADS-1:0] pad_in_i,
  output logic [NPADS-1:0] pad_out_o,
  output logic [NPADS-1:0] pad_oe_o,
  output logic [NPADS-1:0] pad_pu_o,
  input wire logic [NPADS*NFUNC-1:0] alt_out_i,
  input wire logic [NPADS*NFUNC-1:0] alt_oe_i,
  output logic [NPADS*NFUNC-1:0] alt_in_o,
  input wire logic ext_reset_pad_n_i,
  output logic reset_pad_io_out_o,
  output logic reset_pad_io_oe_o,
  output logic reset_pad_pu_o,
  input wire logic cop_reset_i,
  output logic sys_rst_n_o,
  input wire logic [NPADS-1:0] pwm_i,
  output logic [NPADS-1:0] pwm_o,
  output logic pwm_fault_in_o,
  output logic conv_a_ch1_en_o,
  output logic cmp_a_neg_in0_en_o,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic tms_i,
  output logic test_pu_o,
  output logic tap_tdi_o,
  output logic tap_tms_o,
  output logic tap_tck_rise_o,
  input wire logic tap_tdo_i,
  input wire logic tap_shift_i,
  output logic tdo_o,
  output logic tdo_oe_o
);
  logic [NPADS-1:0] port_periph_enable_q;
  logic [NPADS*SELW-1:0] pad_function_select_q;
  logic [NPADS-1:0] dir_q;
  logic [NPADS-1:0] dout_q;
  logic [NPADS-1:0] pull_q;
  logic [4:0] ctl_q;
  logic [NPADS-1:0] fmask_q;
  bus_state_type bus_q;
  bus_state_type bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wr_en;
  logic dev_rst;
  logic rst_req;
  logic [NPADS-1:0] cell_out;
  logic [NPADS-1:0] cell_oe;
  logic [NPADS*NFUNC-1:0] cell_alt_in;
  logic [NPADS-1:0] pad_out_q;
  logic [NPADS-1:0] pad_oe_q;
  logic [NPADS*NFUNC-1:0] alt_in_q;
  logic fault_raw;
  logic fault_q;
  logic [NPADS-1:0] pwm_q;
  logic analog_sel;
  logic conv_en_q;
  logic cmp_en_q;
  logic tck_q;
  logic tck_rise;
  logic tck_fall;
  logic tdi_q;
  logic tms_q;
  logic tdo_q;
  logic tdo_oe_q;
  logic rise_q;

  // Write strobe for one register offset, shared by every configuration register.
  function automatic logic wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = en && (addr == ofs);
  endfunction

  // True when a pad is handed to its peripheral and set to the given function.
  function automatic logic pad_uses(input logic [NPADS-1:0] per, input logic [NPADS*SELW-1:0] sel,
    input int pad, input logic [SELW-1:0] code);
    pad_uses = per[pad] && (pad_sel(sel, pad) == code);
  endfunction

  // Internal reset sources: pad (unless repurposed), watchdog and software.
  assign rst_req = (!ext_reset_pad_n_i && !ctl_q[CTL_RSTIO]) || cop_reset_i || ctl_q[CTL_SWRST];

  reset_release u_reset_release (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .req_i(rst_req),
    .sys_rst_n_o(sys_rst_n_o)
  );

  assign dev_rst = !sys_rst_n_o;

  // Bus slave answers every access one cycle after it appears.
  always_comb begin
    bus_d = bus_idle;
    case (bus_q)
      bus_idle: begin
        if (avs_read_i || avs_write_i) begin
          bus_d = bus_ack;
        end
      end
      bus_ack: begin
        bus_d = bus_idle;
      end
      default: begin
        bus_d = bus_idle;
      end
    endcase
  end

  // Waitrequest drops only in the answer cycle, so a held write lands exactly once.
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q != bus_ack);
  assign wr_en = avs_write_i && (bus_q == bus_ack) && avs_byteenable_i[0];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_q <= bus_idle;
    end else begin
      bus_q <= bus_d;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address_i)
      OFS_PER: rdata_d[NPADS-1:0] = port_periph_enable_q;
      OFS_SEL: rdata_d[NPADS*SELW-1:0] = pad_function_select_q;
      OFS_DIR: rdata_d[NPADS-1:0] = dir_q;
      OFS_DOUT: rdata_d[NPADS-1:0] = dout_q;
      OFS_DIN: rdata_d[NPADS-1:0] = pad_in_i;
      OFS_PULL: rdata_d[NPADS-1:0] = pull_q;
      OFS_CTL: rdata_d[4:0] = ctl_q;
      OFS_FMASK: rdata_d[NPADS-1:0] = fmask_q;
      OFS_STAT: begin
        rdata_d[STAT_FAULT] = fault_q;
        rdata_d[STAT_SHIFT] = tdo_oe_q;
        rdata_d[STAT_RSTPAD] = ext_reset_pad_n_i;
        rdata_d[STAT_CMPSEL] = cmp_en_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data are captured when the request first appears and stand until the next read.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && bus_q == bus_idle) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o = rdata_q;

  // Function selection; any internal reset restores primary functions.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_periph_enable_q <= PER_RST;
      pad_function_select_q <= SEL_RST;
    end else if (dev_rst) begin
      port_periph_enable_q <= PER_RST;
      pad_function_select_q <= SEL_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_PER)) begin
      port_periph_enable_q <= avs_writedata_i[NPADS-1:0];
    end else if (wr_hit(wr_en, avs_address_i, OFS_SEL)) begin
      pad_function_select_q <= avs_writedata_i[NPADS*SELW-1:0];
    end
  end

  // General I/O direction and output data, one bit per pad.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_q <= DIR_RST;
      dout_q <= DOUT_RST;
    end else if (dev_rst) begin
      dir_q <= DIR_RST;
      dout_q <= DOUT_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_DIR)) begin
      dir_q <= avs_writedata_i[NPADS-1:0];
    end else if (wr_hit(wr_en, avs_address_i, OFS_DOUT)) begin
      dout_q <= avs_writedata_i[NPADS-1:0];
    end
  end

  // Pull-ups come back on in reset so an undriven pad never floats.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pull_q <= PULL_RST;
    end else if (dev_rst) begin
      pull_q <= PULL_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_PULL)) begin
      pull_q <= avs_writedata_i[NPADS-1:0];
    end
  end

  // Fault mask picks which PWM outputs a fault may silence.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fmask_q <= FMASK_RST;
    end else if (dev_rst) begin
      fmask_q <= FMASK_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_FMASK)) begin
      fmask_q <= avs_writedata_i[NPADS-1:0];
    end
  end

  // The software reset bit clears itself through the reset it requests.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_q <= CTL_RST;
    end else if (dev_rst) begin
      ctl_q <= CTL_RST;
    end else if (wr_hit(wr_en, avs_address_i, OFS_CTL)) begin
      ctl_q <= avs_writedata_i[4:0];
    end
  end

  // One routing cell per pad; cells share nothing, so pad directions stay independent.
  for (genvar p = 0; p < NPADS; p++) begin : g_pad
    pad_route u_pad_route (
      .per_en_i(port_periph_enable_q[p]),
      .sel_i(pad_sel(pad_function_select_q, p)),
      .gpio_dir_i(dir_q[p]),
      .gpio_out_i(dout_q[p]),
      .alt_out_i(alt_out_i[p*NFUNC +: NFUNC]),
      .alt_oe_i(alt_oe_i[p*NFUNC +: NFUNC]),
      .pad_in_i(pad_in_i[p]),
      .pad_out_o(cell_out[p]),
      .pad_oe_o(cell_oe[p]),
      .alt_in_o(cell_alt_in[p*NFUNC +: NFUNC])
    );
  end

  // Pad drive is registered so a select change never glitches a pin.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      alt_in_q <= '0;
    end else if (dev_rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      alt_in_q <= '0;
    end else begin
      pad_out_q <= cell_out;
      pad_oe_q <= cell_oe;
      alt_in_q <= cell_alt_in;
    end
  end

  assign pad_out_o = pad_out_q;
  assign pad_oe_o = pad_oe_q;
  assign alt_in_o = alt_in_q;
  assign pad_pu_o = pull_q;

  // Reset pad as open-drain I/O: it can only pull low.
  assign reset_pad_io_out_o = 1'b0;
  assign reset_pad_io_oe_o = ctl_q[CTL_RSTIO] && ctl_q[CTL_RSTDRV];
  assign reset_pad_pu_o = 1'b1;

  // Fault pad counts only when that pad is switched to its fault function.
  assign fault_raw = pad_uses(port_periph_enable_q, pad_function_select_q, FAULT_PAD, FAULT_SEL)
    && (pad_in_i[FAULT_PAD] == ctl_q[CTL_FPOL]);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_q <= 1'b0;
      pwm_q <= '0;
    end else begin
      fault_q <= fault_raw;
      // Gating uses the raw fault so the outputs drop on the edge the fault flag rises.
      pwm_q <= pwm_i & ~(fmask_q & {NPADS{fault_raw}});
    end
  end

  assign pwm_fault_in_o = fault_q;
  assign pwm_o = pwm_q;

  // Shared analog pad feeds either the converter channel or the comparator.
  assign analog_sel = pad_uses(port_periph_enable_q, pad_function_select_q, ANALOG_PAD, ANALOG_SEL);

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_en_q <= 1'b0;
      cmp_en_q <= 1'b0;
    end else begin
      conv_en_q <= analog_sel && !ctl_q[CTL_CMPSEL];
      cmp_en_q <= analog_sel && ctl_q[CTL_CMPSEL];
    end
  end

  assign conv_a_ch1_en_o = conv_en_q;
  assign cmp_a_neg_in0_en_o = cmp_en_q;

  // Test clock is oversampled; edges are detected against the core clock.
  assign tck_rise = tck_i && !tck_q;
  assign tck_fall = !tck_i && tck_q;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tck_q <= 1'b1;
      tdi_q <= 1'b1;
      tms_q <= 1'b1;
      rise_q <= 1'b0;
    end else begin
      tck_q <= tck_i;
      rise_q <= tck_rise;
      if (tck_rise) begin
        tdi_q <= tdi_i;
        tms_q <= tms_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_q <= tap_tdo_i;
      tdo_oe_q <= tap_shift_i;
    end
  end

  assign tap_tdi_o = tdi_q;
  assign tap_tms_o = tms_q;
  assign tap_tck_rise_o = rise_q;
  assign test_pu_o = 1'b1;
  // The data-out pad stays an output buffer; only its enable follows shifting.
  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
endmodule

// >>> pin_mux_chk.sv
// Checker for the pin function selector, watching its top-level ports.
// Assumes one core clock and the asynchronous active-low power-on reset.
`timescale 1ns/1ps
module pin_mux_chk
  import pin_mux_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [NPADS-1:0] pad_oe_o,
  input wire logic [NPADS-1:0] pad_pu_o,
  input wire logic [NPADS*NFUNC-1:0] alt_in_o,
  input wire logic cop_reset_i,
  input wire logic sys_rst_n_o,
  input wire logic [NPADS-1:0] pwm_i,
  input wire logic [NPADS-1:0] pwm_o,
  input wire logic pwm_fault_in_o,
  input wire logic conv_a_ch1_en_o,
  input wire logic cmp_a_neg_in0_en_o,
  input wire logic tck_i,
  input wire logic tap_tdi_o,
  input wire logic tap_tck_rise_o,
  input wire logic tdo_o,
  input wire logic tdo_oe_o
);
  logic [7:0] low_cnt_q;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // Counts how long internal reset has been low, saturating so it cannot wrap.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_q <= 8'h00;
    end else if (sys_rst_n_o) begin
      low_cnt_q <= 8'h00;
    end else if (low_cnt_q != 8'hff) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end
  a_rst_pads: assert property (
    !sys_rst_n_o [*3] |-> pad_oe_o == 8'h00 && pad_pu_o == 8'hff && alt_in_o == '0) else $error("pads active in reset");
  a_rel_count: assert property ($rose(sys_rst_n_o) |-> low_cnt_q >= 8'h20) else $error("reset released early");
  a_cop_rst: assert property (cop_reset_i |=> !sys_rst_n_o) else $error("watchdog reset ignored");
  a_tck_pulse: assert property (
    tap_tck_rise_o |-> $past(tck_i) ##1 !tap_tck_rise_o) else $error("bad test clock rise pulse");
  a_tdi_rise: assert property ($changed(tap_tdi_o) |-> $past(tck_i)) else $error("data in not on rise");
  a_tdo_fall: assert property (
    $changed(tdo_o) || $changed(tdo_oe_o) |-> !$past(tck_i)) else $error("data out not on fall");
  a_pwm_gate: assert property (
    sys_rst_n_o && $past(sys_rst_n_o) |-> (pwm_o & ~$past(pwm_i)) == 8'h00) else $error("pwm output not from input");
  a_pwm_pass: assert property (
    sys_rst_n_o && !pwm_fault_in_o |-> pwm_o == $past(pwm_i)) else $error("pwm gated without fault");
  a_analog_one: assert property (!(conv_a_ch1_en_o && cmp_a_neg_in0_en_o)) else $error("both analog paths on");
  a_bus_wait: assert property (
    $rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("bus wait");
endmodule

bind pin_function_selector pin_mux_chk u_pin_mux_chk (.*);

// >>> pad_board.sv
// Board model: pad levels, pull-ups and the open-drain reset line.
// Assumes the design drives a pad only while its enable is high.
`timescale 1ns/1ps
module pad_board (
  input wire logic core_clk_i,
  input wire logic [7:0] drv_out_i,
  input wire logic [7:0] drv_oe_i,
  input wire logic [7:0] pull_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic rst_low_i,
  input wire logic rst_oe_i,
  output logic [7:0] pad_o,
  output logic rst_pad_n_o
);
  logic [7:0] last_q = 8'h00;
  // A floating pad without pull-up flips, so a stale level never passes for a drive.
  assign pad_o = (drv_oe_i & drv_out_i) | (~drv_oe_i & ext_en_i & ext_val_i) |
    (~drv_oe_i & ~ext_en_i & (pull_i | ~last_q));
  always_ff @(posedge core_clk_i) begin
    last_q <= pad_o;
  end
  assign rst_pad_n_o = !(rst_low_i || rst_oe_i);
endmodule

// >>> testbench.sv
// Self-checking bench for the pin function selector.
// Assumes the board model beside it and the bound checker.
`timescale 1ns/1ps
module testbench;
  import pin_mux_pkg::*;
  logic core_clk_i = 0, rstn_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o, cop_reset_i = 0;
  logic [7:0] avs_address_i = '0, pad_in_i, pad_out_o, pad_oe_o, pad_pu_o, pwm_i = '0, pwm_o, ext_en = '0, ext_val = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, rdq, alt_out_i = '0, alt_oe_i = '1, alt_in_o, r = 32'ha78b738f;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic ext_reset_pad_n_i, reset_pad_io_out_o, reset_pad_io_oe_o, reset_pad_pu_o, sys_rst_n_o, pwm_fault_in_o;
  logic conv_a_ch1_en_o, cmp_a_neg_in0_en_o, tck_i = 1, tdi_i = 0, tms_i = 0, test_pu_o, tap_tdi_o, tap_tms_o;
  logic tap_tck_rise_o, tap_tdo_i = 0, tap_shift_i = 0, tdo_o, tdo_oe_o, rst_low = 0;
  int err_count = 0, checked = 0, tcnt = 0, n;
  always #2.5 core_clk_i = ~core_clk_i;
  pin_function_selector u_pin_function_selector (.*);
  pad_board u_pad_board (.core_clk_i(core_clk_i), .drv_out_i(pad_out_o), .drv_oe_i(pad_oe_o), .pull_i(pad_pu_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .rst_low_i(rst_low), .rst_oe_i(reset_pad_io_oe_o), .pad_o(pad_in_i),
    .rst_pad_n_o(ext_reset_pad_n_i));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Undriven pads read their pull-up.
  function automatic logic [7:0] din_exp(input logic [7:0] dir, dout);
    din_exp = (dout & dir) | ~dir;
  endfunction
  function automatic logic [7:0] pwm_exp(input logic [7:0] p, m, input logic f);
    pwm_exp = f ? p & ~m : p;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      chk("bus_timeout", avs_waitrequest_o, 1'b0);
    end
    rdq = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk("readback", rdq, e);
  endtask
  task automatic wait_sys();
    n = 0;
    while (sys_rst_n_o !== 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    if (sys_rst_n_o !== 1'b1) begin
      chk("sys_timeout", sys_rst_n_o, 1'b1);
    end
  endtask
  task automatic tick(input logic [3:0] v);
    {tap_tdo_i, tap_shift_i, tms_i, tdi_i} <= v;
    cyc(4);
    tck_i <= 1'b0;
    cyc(6);
    chk("tap_out", {tdo_oe_o, tdo_o & v[2]}, {v[2], v[3] & v[2]});
    tck_i <= 1'b1;
    cyc(6);
    chk("tap_in", {tap_tms_o, tap_tdi_o}, v[1:0]);
  endtask
  always @(posedge core_clk_i) begin
    tcnt++;
    if (tcnt == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    cyc(20);
    rstn_i <= 1'b1;
    wait_sys();
    chk("idle", {pad_oe_o, pad_pu_o, test_pu_o, reset_pad_pu_o, reset_pad_io_out_o, tdo_oe_o}, {8'h00, 8'hff, 4'hc});
    chk("alt", alt_in_o, '0);
    rd(OFS_PER, PER_RST);
    rd(OFS_CTL, CTL_RST);
    rd(8'h24, '0);
    for (int i = 0; i < 6; i++) begin
      r = nxt(r);
      alt_out_i <= r;
      pwm_i <= r[23:16];
      bus(1'b1, OFS_SEL, r[31:16]);
      bus(1'b1, OFS_DIR, r[7:0]);
      bus(1'b1, OFS_DOUT, r[15:8]);
      cyc(4);
      chk("dir", pad_oe_o, r[7:0]);
      chk("alt", alt_in_o, '0);
      rd(OFS_DIN, din_exp(r[7:0], r[15:8]));
    end
    bus(1'b1, OFS_PER, 32'h08);
    for (int f = 0; f < NFUNC; f++) begin
      r = nxt(r);
      alt_out_i <= r;
      bus(1'b1, OFS_SEL, 32'(f) << 6);
      cyc(5);
      chk("pad3", {pad_oe_o[3], pad_out_o[3]}, {1'b1, r[12+f]});
      chk("alt", alt_in_o, 32'(r[12+f]) << (12 + f));
    end
    alt_oe_i <= '0;
    ext_en <= 8'h40;
    r = nxt(r);
    pwm_i <= r[15:8];
    bus(1'b1, OFS_PER, 32'h40);
    bus(1'b1, OFS_SEL, 32'(FAULT_SEL) << (2 * FAULT_PAD));
    bus(1'b1, OFS_FMASK, r[7:0]);
    for (int k = 0; k < 2; k++) begin
      ext_val <= k[0] ? 8'h40 : 8'h00;
      cyc(4);
      chk("fault", pwm_fault_in_o, k[0]);
      chk("pwm", pwm_o, pwm_exp(r[15:8], r[7:0], k[0]));
      rd(OFS_STAT, (32'h1 << STAT_RSTPAD) | (32'(k[0]) << STAT_FAULT));
    end
    avs_byteenable_i <= 4'he;
    bus(1'b1, OFS_FMASK, '0);
    avs_byteenable_i <= 4'hf;
    rd(OFS_FMASK, r[7:0]);
    bus(1'b1, OFS_PER, 32'h02);
    bus(1'b1, OFS_SEL, '0);
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, OFS_CTL, 32'h04 | (32'(k) << CTL_CMPSEL));
      cyc(3);
      chk("analog", {conv_a_ch1_en_o, cmp_a_neg_in0_en_o}, {!k[0], k[0]});
    end
    for (int i = 0; i < 8; i++) begin
      r = nxt(r);
      tick(r[3:0]);
    end
    r = nxt(r);
    bus(1'b1, OFS_PULL, {24'h0, r[7:0]});
    rd(OFS_PULL, r[7:0]);
    chk("pull", pad_pu_o, r[7:0]);
    rst_low <= 1'b1;
    cyc(3);
    chk("sys", sys_rst_n_o, 1'b0);
    rst_low <= 1'b0;
    wait_sys();
    // Two edges more than the count: release is registered one edge after it, and the rise is only seen at the following edge.
    chk("release", n, 32'(RST_RELEASE_CYCLES) + 2);
    chk("pull_rst", pad_pu_o, PULL_RST);
    rd(OFS_PER, PER_RST);
    bus(1'b1, OFS_CTL, 32'h15);
    cyc(40);
    chk("pad_io", {reset_pad_io_oe_o, sys_rst_n_o}, 2'b11);
    cop_reset_i <= 1'b1;
    cyc(2);
    chk("cop", sys_rst_n_o, 1'b0);
    cop_reset_i <= 1'b0;
    wait_sys();
    rd(OFS_CTL, CTL_RST);
    bus(1'b1, OFS_CTL, 32'(CTL_RST) | (32'h1 << CTL_SWRST));
    cyc(2);
    chk("sw_rst", sys_rst_n_o, 1'b0);
    wait_sys();
    rd(OFS_CTL, CTL_RST);
    end_sim();
  end
endmodule
